// [ced_dev.sv]
// device end: configuration memory crc checker with serial access port
`timescale 1ns/10ps
`default_nettype none

module ced_dev #(
  parameter int DEPTH  = 16,  // configuration memory words
  parameter int ADDR_W = 4
)(
  input  wire logic                              core_clk,
  input  wire logic                              rstn,
  ced_if.dev                                     lnk,
  input  wire logic                              cfg_wr,
  input  wire logic [ADDR_W-1:0]                 cfg_addr,
  input  wire logic [31:0]                       cfg_data,
  input  wire logic                              cfg_done,
  input  wire logic                              det_enable,
  input  wire logic [ced_pkg::DIV_EXP_W-1:0]     div_exp,
  output logic                                   user_mode,
  output logic                                   pass_done
);

  logic [31:0]                  mem_r [DEPTH];
  ced_pkg::ced_phase_e          ph_r;
  logic [ced_pkg::DIV_EXP_W-1:0] exp_r;
  logic [ced_pkg::DIV_CNT_W-1:0] div_r;
  logic                         tick_r;
  logic [ADDR_W-1:0]            addr_r;
  logic [31:0]                  run_r;
  logic [31:0]                  store_r;
  logic [31:0]                  sig_r;
  logic                         err_r;
  logic [31:0]                  sreg_r;
  logic                         rq_n_q;
  logic                         last_word;
  logic [31:0]                  run_nxt;
  logic                         reset_all;

  assign last_word = (addr_r == ADDR_W'(DEPTH - 1));
  assign run_nxt   = ced_pkg::ced_crc_word(run_r, mem_r[addr_r]);
  // a low request sends the device back to configuration
  assign reset_all = !rq_n_q;

  ////////////////////////////////////////////////////////////////////////
  // request pin comes from the far system, so it is registered once
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rq_n_q <= 1'b1;
    else
      rq_n_q <= lnk.reconfig_request_n;
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration memory; writes in user mode model upsets
  always_ff @(posedge core_clk)
  begin
    if (cfg_wr)
      mem_r[cfg_addr] <= cfg_data;
  end

  ////////////////////////////////////////////////////////////////////////
  // divisor latched on leaving configuration, clamped to 2**8
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      exp_r <= ced_pkg::DIV_EXP_MAX;
    else if (ph_r == ced_pkg::CED_CFG && cfg_done)
      exp_r <= (div_exp > ced_pkg::DIV_EXP_MAX) ? ced_pkg::DIV_EXP_MAX
                                                : div_exp;
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator divider: one tick every 2**n core cycles
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (ph_r != ced_pkg::CED_USER)
    begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (div_r == '0);
      if (div_r == '0)
        div_r <= ced_pkg::DIV_CNT_W'((9'h001 << exp_r) - 9'h001);
      else
        div_r <= div_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase and crc walk; in user mode one word per divided tick, so a pass
  // takes DEPTH ticks of the divided clock
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ph_r      <= ced_pkg::CED_CFG;
      addr_r    <= '0;
      run_r     <= ced_pkg::CRC_INIT;
      store_r   <= ced_pkg::SIG_CLEAN;
      sig_r     <= ced_pkg::SIG_CLEAN;
      err_r     <= 1'b0;
      user_mode <= 1'b0;
      pass_done <= 1'b0;
    end
    else if (reset_all)
    begin
      ph_r      <= ced_pkg::CED_CFG;
      addr_r    <= '0;
      run_r     <= ced_pkg::CRC_INIT;
      sig_r     <= ced_pkg::SIG_CLEAN;
      err_r     <= 1'b0;
      user_mode <= 1'b0;
      pass_done <= 1'b0;
    end
    else
    begin
      pass_done <= 1'b0;
      case (ph_r)
        ced_pkg::CED_CFG:
        begin
          if (cfg_done)
          begin
            addr_r <= '0;
            run_r  <= ced_pkg::CRC_INIT;
            ph_r   <= ced_pkg::CED_SEED;
          end
        end
        ced_pkg::CED_SEED:
        begin
          // precompute over fresh contents at full rate
          addr_r <= addr_r + 1'b1;
          run_r  <= run_nxt;
          if (last_word)
          begin
            store_r   <= run_nxt;
            addr_r    <= '0;
            run_r     <= ced_pkg::CRC_INIT;
            ph_r      <= det_enable ? ced_pkg::CED_USER : ced_pkg::CED_CFG;
            user_mode <= det_enable;
          end
        end
        ced_pkg::CED_USER:
        begin
          // only the divided tick advances the
          if (tick_r)
          begin
            addr_r <= last_word ? '0 : addr_r + 1'b1;
            run_r  <= last_word ? ced_pkg::CRC_INIT : run_nxt;
            if (last_word)
            begin
              // zero when clean; flag follows each pass alone
              sig_r     <= run_nxt ^ store_r;
              err_r     <= (run_nxt != store_r);
              pass_done <= 1'b1;
            end
          end
        end
        default: ph_r <= ced_pkg::CED_CFG;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access shift register, moved only on access clock edges
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sreg_r <= '0;
    else if (lnk.acc_clk_en)
    begin
      if (lnk.shift_n_load)
        sreg_r <= {1'b0, sreg_r[31:1]};
      else
        sreg_r <= lnk.load_src ? sig_r : store_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins: flag timed by the engine clock; pin always enabled
  assign lnk.read_out = sreg_r[0];
  assign lnk.err_o    = err_r;
  assign lnk.err_oe   = 1'b1;

endmodule : ced_dev

`default_nettype wire

// [ced_if.sv]
// interface joining the crc error detector and the user core logic
`timescale 1ns/10ps
`default_nettype none

interface ced_if;
  logic acc_clk_en;          // access clock rising edge, one-cycle pulse
  logic shift_n_load;        // 1 shift, 0 parallel load
  logic load_src;            // 0 stored crc, 1 signature
  logic read_out;            // serial read bit
  logic err_o;               // soft error flag driven onto the pin
  logic err_oe;              // pin output enable
  logic bidirectional_pin;   // level seen back from the pin
  logic reconfig_request_n;  // active-low reconfiguration request

  // pin level resolves from the enable; undriven pin reads low
  assign bidirectional_pin = err_oe ? err_o : 1'b0;

  modport dev
  (
    input  acc_clk_en,
    input  shift_n_load,
    input  load_src,
    output read_out,
    output err_o,
    output err_oe,
    input  reconfig_request_n
  );

  modport usr
  (
    output acc_clk_en,
    output shift_n_load,
    output load_src,
    input  read_out,
    input  bidirectional_pin,
    output reconfig_request_n
  );
endinterface : ced_if

`default_nettype wire

// [ced_pkg.sv]
// shared constants and types for the config crc error detector
`default_nettype none

package ced_pkg;

  // crc engine
  localparam int          CRC_W       = 32;
  localparam logic [31:0] CRC_POLY    = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] SIG_CLEAN   = 32'h00000000;

  // error detection clock divisor 2**n, n in 0..8
  localparam int          DIV_EXP_W   = 4;
  localparam logic [3:0]  DIV_EXP_MAX = 4'h8;
  localparam int          DIV_CNT_W   = 8;

  // access port
  localparam int          SHIFT_BITS  = 32;
  localparam logic [5:0]  SHIFT_LAST  = 6'h1f;
  localparam logic [1:0]  LOAD_CYCLES = 2'h2;

  // timing at the 20 MHz core clock
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          RECONF_PULSE_NS = 500;
  localparam int          RECONF_PULSE_CYC =
    (RECONF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // device phases
  typedef enum logic [1:0]
  {
    CED_CFG  = 2'b00,
    CED_SEED = 2'b01,
    CED_USER = 2'b10
  } ced_phase_e;

  // user-side reader states
  typedef enum logic [1:0]
  {
    CED_IDLE  = 2'b00,
    CED_LOAD  = 2'b01,
    CED_SHIFT = 2'b10
  } ced_rd_e;

  // crc-32 of one word folded into a running value, msb first
  function automatic logic [31:0] ced_crc_word(input logic [31:0] crc,
                                               input logic [31:0] data);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--)
    begin
      if (c[31] ^ data[i])
        c = {c[30:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[30:0], 1'b0};
    end
    return c;
  endfunction : ced_crc_word

endpackage : ced_pkg

`default_nettype wire

// [ced_sva.sv]
// assertions on the link between the detector and the user logic
`timescale 1ns/10ps
`default_nettype none

module ced_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic acc_clk_en,
  input wire logic shift_n_load,
  input wire logic load_src,
  input wire logic read_out,
  input wire logic err_o,
  input wire logic err_oe,
  input wire logic bidirectional_pin,
  input wire logic reconfig_request_n
);
  logic [5:0] shf_r;
  logic [1:0] ld_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // shifts since load (3f = never loaded) and load edges in a row
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      shf_r <= 6'h3f;
    else if (acc_clk_en && !shift_n_load)
      shf_r <= 6'h00;
    else if (acc_clk_en && shf_r < 6'h3e)
      shf_r <= shf_r + 6'h01;
  end

  // saturates at two, which is all the load rule needs
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ld_r <= 2'h0;
    else if (shift_n_load)
      ld_r <= 2'h0;
    else if (acc_clk_en && ld_r != 2'h2)
      ld_r <= ld_r + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_pin_enable: assert property (err_oe)
    else $error("pin enable dropped");
  a_acc_pulse: assert property (acc_clk_en |=> !acc_clk_en)
    else $error("access edge longer than one cycle");
  a_read_stable: assert property (
    !acc_clk_en |=> $stable(read_out))
    else $error("serial bit moved without access edge");
  a_shift_drain: assert property (
    shf_r >= 6'h20 && shf_r != 6'h3f |-> !read_out)
    else $error("serial bit not zero after 32 shifts");
  a_load_two: assert property ($rose(shift_n_load) |-> ld_r == 2'h2)
    else $error("load held under two access edges");
  a_pulse_width: assert property (
    $fell(reconfig_request_n) |-> !reconfig_request_n[*8]
      ##1 !reconfig_request_n[*2] ##1 reconfig_request_n)
    else $error("reconfiguration pulse width wrong");
  a_recover_cause: assert property (
    $fell(reconfig_request_n) |-> $past(bidirectional_pin, 2))
    else $error("reconfiguration without error flag");
  a_reconf_clear: assert property (
    !reconfig_request_n |-> ##[0:2] !err_o)
    else $error("error flag kept through reconfiguration");

  // main scenarios reached
  c_load_sig: cover property (acc_clk_en && !shift_n_load && load_src);
  c_err_rise: cover property ($rose(err_o));
  c_recover: cover property ($fell(reconfig_request_n));
endmodule : ced_sva

`default_nettype wire

// [ced_user.sv]
// user core logic end: reads the crc registers and requests reconfiguration
`timescale 1ns/10ps
`default_nettype none

module ced_user #(
  parameter int ACC_DIV = 4  // core cycles per access clock period
)(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  ced_if.usr               lnk,
  input  wire logic        rd_start,
  input  wire logic        rd_src,
  input  wire logic        recover_ok,
  output logic             rd_busy,
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  output logic             err_seen
);

  ced_pkg::ced_rd_e   st_r;
  logic [7:0]         div_r;
  logic               tick_r;
  logic [1:0]         ld_cnt_r;
  logic [5:0]         bit_r;
  logic [31:0]        cap_r;
  logic               src_r;
  logic               snl_r;
  logic               rq_n_r;
  logic [7:0]         pulse_r;

  ////////////////////////////////////////////////////////////////////////
  // access clock: one enable pulse every ACC_DIV core cycles
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (div_r == 8'h00);
      div_r  <= (div_r == 8'(ACC_DIV - 1)) ? 8'h00 : div_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reader: hold load low two ticks, then shift and capture 32 bits
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r     <= ced_pkg::CED_IDLE;
      ld_cnt_r <= 2'h0;
      bit_r    <= 6'h00;
      cap_r    <= 32'h00000000;
      src_r    <= 1'b0;
      snl_r    <= 1'b1;
      rd_valid <= 1'b0;
      rd_busy  <= 1'b0;
      rd_data  <= 32'h00000000;
    end
    else
    begin
      rd_valid <= 1'b0;
      case (st_r)
        ced_pkg::CED_IDLE:
        begin
          if (rd_start)
          begin
            src_r    <= rd_src;
            snl_r    <= 1'b0;
            ld_cnt_r <= 2'h0;
            rd_busy  <= 1'b1;
            st_r     <= ced_pkg::CED_LOAD;
          end
        end
        ced_pkg::CED_LOAD:
        begin
          // load needs two access edges with the control low
          if (tick_r)
          begin
            ld_cnt_r <= ld_cnt_r + 2'h1;
            if (ld_cnt_r + 2'h1 == ced_pkg::LOAD_CYCLES)
            begin
              snl_r <= 1'b1;
              bit_r <= 6'h00;
              st_r  <= ced_pkg::CED_SHIFT;
            end
          end
        end
        ced_pkg::CED_SHIFT:
        begin
          // bit 0 stands after the load; 31 more ticks bring the rest
          if (tick_r)
          begin
            cap_r[bit_r[4:0]] <= lnk.read_out;
            bit_r             <= bit_r + 6'h01;
            if (bit_r == ced_pkg::SHIFT_LAST)
            begin
              rd_data  <= {lnk.read_out, cap_r[30:0]};
              rd_valid <= 1'b1;
              rd_busy  <= 1'b0;
              st_r     <= ced_pkg::CED_IDLE;
            end
          end
        end
        default:
        begin
          rd_busy <= 1'b0;
          st_r    <= ced_pkg::CED_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // recovery: trust the pin flag, not the read data
  // pulse the request low only when the system says it is safe
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rq_n_r   <= 1'b1;
      pulse_r  <= 8'h00;
      err_seen <= 1'b0;
    end
    else
    begin
      err_seen <= lnk.bidirectional_pin;  // read back through the pin
      if (pulse_r != 8'h00)
      begin
        pulse_r <= pulse_r - 8'h01;
        rq_n_r  <= (pulse_r == 8'h01);
      end
      else if (err_seen && recover_ok)
      begin
        pulse_r <= 8'(ced_pkg::RECONF_PULSE_CYC);
        rq_n_r  <= 1'b0;
      end
    end
  end

  // busy is a flop of its own so the output stays glitch free
  assign lnk.acc_clk_en         = tick_r;
  assign lnk.shift_n_load       = snl_r;
  assign lnk.load_src           = src_r;
  assign lnk.reconfig_request_n = rq_n_r;

endmodule : ced_user

`default_nettype wire

// [config_crc_error_detect_tb.sv]
// self-checking bench for both detector ends joined by the link
`timescale 1ns/10ps
`default_nettype none

module config_crc_error_detect_tb;
  logic        core_clk;
  logic        rstn;
  logic        cfg_wr;
  logic [3:0]  cfg_addr;
  logic [31:0] cfg_data;
  logic        cfg_done;
  logic        det_enable;
  logic [3:0]  div_exp;
  logic        user_mode;
  logic        pass_done;
  logic        rd_start;
  logic        rd_src;
  logic        recover_ok;
  logic        rd_busy;
  logic        rd_valid;
  logic [31:0] rd_data;
  logic        err_seen;
  logic [31:0] mem [16];
  logic [31:0] stored;
  int          mismatches;
  int          n_tests;

  ced_if lnk ();

  ced_dev #(.DEPTH(16), .ADDR_W(4)) ced_dev_inst (
    .core_clk(core_clk), .rstn(rstn), .lnk(lnk), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_done(cfg_done),
    .det_enable(det_enable), .div_exp(div_exp), .user_mode(user_mode),
    .pass_done(pass_done));

  ced_user #(.ACC_DIV(4)) ced_user_inst (
    .core_clk(core_clk), .rstn(rstn), .lnk(lnk), .rd_start(rd_start),
    .rd_src(rd_src), .recover_ok(recover_ok), .rd_busy(rd_busy),
    .rd_valid(rd_valid), .rd_data(rd_data), .err_seen(err_seen));

  ced_sva ced_sva_inst (
    .core_clk(core_clk), .rstn(rstn), .acc_clk_en(lnk.acc_clk_en),
    .shift_n_load(lnk.shift_n_load), .load_src(lnk.load_src),
    .read_out(lnk.read_out), .err_o(lnk.err_o), .err_oe(lnk.err_oe),
    .bidirectional_pin(lnk.bidirectional_pin),
    .reconfig_request_n(lnk.reconfig_request_n));

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // bounded wait; n is edges counted until s sampled at level v
  task automatic wait_for(ref logic s, input logic v, input int lim,
                          output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (s !== v && n < lim);
    if (s !== v)
    begin
      mismatches++;
      end_of_test();
    end
  endtask : wait_for

  // reference crc, msb first, no final xor
  function automatic logic [31:0] mem_crc();
    logic [31:0] c;
    c = ced_pkg::CRC_INIT;
    foreach (mem[w])
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ ({32{c[31] ^ mem[w][b]}} & ced_pkg::CRC_POLY);
    return c;
  endfunction : mem_crc

  task automatic wr_word(input int a, input logic [31:0] d);
    @(posedge core_clk);
    cfg_wr   <= 1'b1;
    cfg_addr <= a[3:0];
    cfg_data <= d;
    @(posedge core_clk);
    cfg_wr   <= 1'b0;
  endtask : wr_word

  task automatic configure(input logic [3:0] n);
    int k;
    foreach (mem[a])
      wr_word(a, mem[a]);
    cfg_done <= 1'b1;
    div_exp  <= n;
    @(posedge core_clk);
    cfg_done <= 1'b0;
    wait_for(user_mode, 1'b1, 20, k);
    stored = mem_crc();
  endtask : configure

  task automatic read_reg(input logic src, input logic [31:0] exp);
    int k;
    @(posedge core_clk);
    rd_start <= 1'b1;
    rd_src   <= src;
    @(posedge core_clk);
    rd_start <= 1'b0;
    @(posedge core_clk);
    chk(rd_busy, 1'b1);
    wait_for(rd_valid, 1'b1, 200, k);
    chk(rd_data, exp);
    chk(rd_busy, 1'b0);
  endtask : read_reg

  // period between two pass-end pulses
  task automatic pass_gap(input int exp);
    int k;
    wait_for(pass_done, 1'b1, 5000, k);
    wait_for(pass_done, 1'b1, 5000, k);
    chk(k, exp);
  endtask : pass_gap

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_clean();
    configure(4'h0);
    chk(user_mode, 1'b1);
    read_reg(1'b0, stored);
    read_reg(1'b1, ced_pkg::SIG_CLEAN);
    chk(err_seen, 1'b0);
    pass_gap(16);
    $display("clean pass test done");
  endtask : test_clean

  task automatic test_upset();
    logic [31:0] good;
    good = mem[5];
    mem[5] = good ^ 32'h00000100;
    wr_word(5, mem[5]);
    pass_gap(16);
    chk(lnk.bidirectional_pin, 1'b1);
    read_reg(1'b1, mem_crc() ^ stored);
    mem[5] = good;
    wr_word(5, good);
    chk(lnk.err_o, 1'b1);
    pass_gap(16);
    pass_gap(16);
    chk(lnk.err_o, 1'b0);
    mem[5] = 32'h0bad0bad;
    wr_word(5, mem[5]);
    pass_gap(16);
    // err_seen trails the pin by one register stage
    @(posedge core_clk);
    chk(err_seen, 1'b1);
    $display("upset test done");
  endtask : test_upset

  task automatic test_recover();
    int k;
    recover_ok <= 1'b1;
    wait_for(user_mode, 1'b0, 40, k);
    recover_ok <= 1'b0;
    chk(lnk.err_o, 1'b0);
    configure(4'h3);
    pass_gap(128);
    chk(err_seen, 1'b0);
    $display("recovery test done");
  endtask : test_recover

  task automatic test_divisor();
    rstn <= 1'b0;
    @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk(user_mode, 1'b0);
    // detection disabled: seed pass ends back in configuration
    det_enable <= 1'b0;
    cfg_done   <= 1'b1;
    @(posedge core_clk);
    cfg_done   <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(user_mode, 1'b0);
    chk(pass_done, 1'b0);
    det_enable <= 1'b1;
    configure(4'h9);
    pass_gap(4096);
    $display("divisor clamp test done");
  endtask : test_divisor

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    core_clk   = 1'b0;
    rstn       = 1'b0;
    cfg_wr     = 1'b0;
    cfg_addr   = 4'h0;
    cfg_data   = 32'h00000000;
    cfg_done   = 1'b0;
    det_enable = 1'b1;
    div_exp    = 4'h0;
    rd_start   = 1'b0;
    rd_src     = 1'b0;
    recover_ok = 1'b0;
    mismatches = 0;
    n_tests    = 0;
    foreach (mem[i])
      mem[i] = {4{i[7:0]}} ^ 32'h5a3c0f96;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    test_clean();
    test_upset();
    test_recover();
    test_divisor();
    end_of_test();
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end
endmodule : config_crc_error_detect_tb

`default_nettype wire
